// ===== logic/pgpio_pkg.sv
/*
 * Constants, register map, carrier structs and shared functions of the
 * two-port general-purpose I/O block.
 * Assumes an APB master on the CPU clock and an external bus controller
 * that presents its mode and address on the bus carrier struct.
 */
// Contract
// (RQ1) First-port direction bits 7-0: 0 input high-z, 1 output; bits 15-8 reserved.
// (RQ2) Demultiplexed external bus enabled: first port becomes the full 16-bit address bus.
// (RQ3) Top four first-port high lines feed capture channels twenty-four to twenty-seven.
// (RQ4) Those four capture lines are sampled once every eight clock cycles.
// (RQ5) Capture on the four upper lines keeps working in address bus mode.
// (RQ6) Outside parties drive capture signals only when address output is off.
// (RQ7) Demultiplexed external access drives the 16-bit address as first-port output.
// (RQ8) Multiplexed mode without demultiplexed selection leaves the first port as GPIO.
// (RQ9) Bus mode: bus controller sets direction and latch loads, latch takes address.
// (RQ10) Software must not write the first-port latch during external bus mode.
// (RQ11) Bus modes off: software direction register value becomes active again.
// (RQ12) Second port is 16 lines, each with its own direction.
// (RQ13) Second-port direction bits: 0 high-z input, 1 output.
// (RQ14) Second-port driver-type bits: 0 push-pull, 1 open-drain.
// (RQ15) Second-port data register holds sixteen read/write output latch bits.
// (RQ16) Writing one first-port byte half leaves the other half unchanged.
// (RQ17) Open-drain output drives low for latch 0, releases pin for latch 1.
// (RQ18) Data read returns pin level for inputs, latch contents for outputs.
package pgpio_pkg;

    localparam int unsigned PGPIO_ADDR_W   = 18;
    localparam int unsigned PGPIO_DATA_W   = 32;
    localparam int unsigned PGPIO_PORT_W   = 16;
    localparam int unsigned PGPIO_HALF_W   = 8;
    localparam int unsigned PGPIO_CAP_N    = 4;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [15:0] PGPIO_IDX_PORT1_LOW_DIRECTION  = 16'hF104;
    localparam logic [15:0] PGPIO_IDX_PORT1_HIGH_DIRECTION = 16'hF106;
    localparam logic [15:0] PGPIO_IDX_PORT2_DRIVER_TYPE    = 16'hF1C2;
    localparam logic [15:0] PGPIO_IDX_PORT2_DATA_LATCH     = 16'hFFC0;
    localparam logic [15:0] PGPIO_IDX_PORT2_DIRECTION      = 16'hFFC2;
    localparam logic [15:0] PGPIO_IDX_PORT1_LOW_DATA       = 16'hFF04;
    localparam logic [15:0] PGPIO_IDX_PORT1_HIGH_DATA      = 16'hFF06;
    localparam logic [15:0] PGPIO_IDX_IRQ_STATUS           = 16'hF180;
    localparam logic [15:0] PGPIO_IDX_IRQ_MASK             = 16'hF182;
    localparam logic [15:0] PGPIO_IDX_EDGE_SELECT          = 16'hF184;

    localparam logic [7:0]  PGPIO_RST_HALF_DIR   = 8'h00;
    localparam logic [7:0]  PGPIO_RST_HALF_DATA  = 8'h00;
    localparam logic [15:0] PGPIO_RST_PORT2      = 16'h0000;
    localparam logic [3:0]  PGPIO_RST_IRQ        = 4'h0;
    localparam logic [7:0]  PGPIO_RST_EDGE       = 8'h00;

    // capture lines sit in bits 7-4 of the first-port high half, i.e. lines 15-12
    localparam int unsigned PGPIO_CAP_LSB        = 12;
    // edge select: bits 3-0 rising enables, bits 7-4 falling enables
    localparam int unsigned PGPIO_EDGE_RISE_LSB  = 0;
    localparam int unsigned PGPIO_EDGE_FALL_LSB  = 4;

    localparam int unsigned PGPIO_SAMPLE_CYCLES  = 8;
    localparam logic [2:0]  PGPIO_SAMPLE_LAST    = 3'(PGPIO_SAMPLE_CYCLES - 1);

    typedef struct packed {
        logic                    psel;
        logic                    penable;
        logic                    pwrite;
        logic [PGPIO_ADDR_W-1:0] paddr;
        logic [PGPIO_DATA_W-1:0] pwdata;
    } pgpio_apb_req_type;

    typedef struct packed {
        logic [PGPIO_DATA_W-1:0] prdata;
        logic                    pready;
        logic                    pslverr;
    } pgpio_apb_rsp_type;

    typedef struct packed {
        logic                    ext_en;
        logic                    demux_sel;
        logic                    addr_load;
        logic                    addr_oe;
        logic [PGPIO_PORT_W-1:0] addr;
    } pgpio_bus_type;

    typedef struct packed {
        logic [7:0]              port1_lo_dir;
        logic [7:0]              port1_hi_dir;
        logic [7:0]              port1_lo_latch;
        logic [7:0]              port1_hi_latch;
        logic [15:0]             port2_latch;
        logic [15:0]             port2_dir;
        logic [15:0]             port2_drv;
        logic [3:0]              irq_status;
        logic [3:0]              irq_mask;
        logic [7:0]              edge_sel;
        logic [PGPIO_DATA_W-1:0] prdata;
        logic                    rd_err;
    } pgpio_state_type;

    typedef struct packed {
        logic [2:0]  cnt;
        logic        primed;
        logic [3:0]  sampled;
        logic [3:0]  rise;
        logic [3:0]  fall;
    } pgpio_cap_state_type;

    function automatic logic [15:0] pgpio_read_mix(input logic [15:0] dir,
                                                   input logic [15:0] latch,
                                                   input logic [15:0] pin);
        pgpio_read_mix = (dir & latch) | (~dir & pin);
    endfunction

    function automatic logic pgpio_hit(input logic [PGPIO_ADDR_W-1:0] addr,
                                       input logic [15:0]             idx);
        pgpio_hit = (addr[1:0] == 2'h0) && (addr[PGPIO_ADDR_W-1:2] == idx);
    endfunction

endpackage

// ===== logic/pgpio_pad.sv
/*
 * Output stage of one 16-line port: turns latch, direction and driver type
 * into a pin value and an output enable.
 * Assumes the bench resolves the pin wire from out and oe.
 */
`timescale 1ns/1ns
module pgpio_pad
    import pgpio_pkg::*;
(
    input  wire logic [PGPIO_PORT_W-1:0] i_latch,
    input  wire logic [PGPIO_PORT_W-1:0] i_dir,
    input  wire logic [PGPIO_PORT_W-1:0] i_od,
    output logic      [PGPIO_PORT_W-1:0] o_out,
    output logic      [PGPIO_PORT_W-1:0] o_oe
);

    always_comb begin
        for (int i = 0; i < PGPIO_PORT_W; i++) begin
            if (!i_dir[i]) begin
                o_out[i] = 1'b0;                         // [RQ13] [RQ1]
                o_oe[i]  = 1'b0;
            end else if (i_od[i]) begin
                o_out[i] = 1'b0;                         // [RQ14] [RQ17]
                o_oe[i]  = ~i_latch[i];
            end else begin
                o_out[i] = i_latch[i];                   // [RQ14]
                o_oe[i]  = 1'b1;
            end
        end
    end

endmodule

// ===== logic/pgpio_capture.sv
/*
 * Sampler for the four capture lines: takes a sample every eight clock
 * cycles and reports rising and falling changes between samples.
 * Assumes pin inputs synchronous to the clock; i_ce freezes all state.
 */
`timescale 1ns/1ns
module pgpio_capture
    import pgpio_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_ce,
    input  wire logic [PGPIO_CAP_N-1:0] i_lines,
    output logic      [PGPIO_CAP_N-1:0] o_sampled,
    output logic      [PGPIO_CAP_N-1:0] o_rise,
    output logic      [PGPIO_CAP_N-1:0] o_fall
);

    pgpio_cap_state_type st_r;
    pgpio_cap_state_type st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.rise = 4'h0;
        st_nxt.fall = 4'h0;
        if (st_r.cnt == PGPIO_SAMPLE_LAST) begin
            st_nxt.cnt     = 3'h0;
            st_nxt.sampled = i_lines;                    // [RQ4]
            st_nxt.primed  = 1'b1;
            // first sample after reset only primes, so no false edge
            if (st_r.primed) begin
                st_nxt.rise = i_lines & ~st_r.sampled;
                st_nxt.fall = ~i_lines & st_r.sampled;
            end
        end else begin
            st_nxt.cnt = st_r.cnt + 3'h1;                // [RQ4]
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_sampled = st_r.sampled;
    assign o_rise    = st_r.rise;
    assign o_fall    = st_r.fall;

endmodule

// ===== logic/pgpio_top.sv
/*
 * Two-port general-purpose I/O block: register file on APB, first-port
 * takeover by the external bus controller, second-port push-pull or
 * open-drain lines, and capture-line change interrupts.
 * Assumes the bus controller drives the bus carrier on the same clock
 * and that pin inputs are already synchronous to I_CLK.
 */
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module pgpio_top
    import pgpio_pkg::*;
(
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET_N,
    input  wire logic                    I_CE,
    input  wire pgpio_apb_req_type       I_APB,
    output pgpio_apb_rsp_type            O_APB,
    input  wire pgpio_bus_type           I_BUS,
    input  wire logic [PGPIO_PORT_W-1:0] I_PORT1_IN,
    output logic      [PGPIO_PORT_W-1:0] O_PORT1_OUT,
    output logic      [PGPIO_PORT_W-1:0] O_PORT1_OE,
    input  wire logic [PGPIO_PORT_W-1:0] I_PORT2_IN,
    output logic      [PGPIO_PORT_W-1:0] O_PORT2_OUT,
    output logic      [PGPIO_PORT_W-1:0] O_PORT2_OE,
    output logic      [PGPIO_CAP_N-1:0]  O_CAPTURE,
    output logic      [PGPIO_CAP_N-1:0]  O_CAPTURE_EVT,
    output logic                         O_IRQ
);

    pgpio_state_type         st_r;
    pgpio_state_type         st_nxt;

    logic                    takeover;
    logic [PGPIO_PORT_W-1:0] port1_latch;
    logic [PGPIO_PORT_W-1:0] port1_dir_eff;
    logic [PGPIO_PORT_W-1:0] port1_rd;
    logic [PGPIO_PORT_W-1:0] port2_rd;
    logic [PGPIO_CAP_N-1:0]  cap_sampled;
    logic [PGPIO_CAP_N-1:0]  cap_rise;
    logic [PGPIO_CAP_N-1:0]  cap_fall;
    logic [PGPIO_CAP_N-1:0]  cap_events;
    logic                    setup_ph;
    logic                    wr_acc;
    logic [15:0]             wdata16;
    logic                    mapped;

    // multiplexed modes without demux selection leave the port to software
    assign takeover = I_BUS.ext_en && I_BUS.demux_sel;          // [RQ2] [RQ8]

    assign port1_latch = {st_r.port1_hi_latch, st_r.port1_lo_latch};

    // direction registers are never touched by the bus, so they come back as written
    assign port1_dir_eff = takeover ? {PGPIO_PORT_W{I_BUS.addr_oe}} :     // [RQ9]
                                      {st_r.port1_hi_dir, st_r.port1_lo_dir}; // [RQ11]

    assign port1_rd = pgpio_read_mix(port1_dir_eff, port1_latch, I_PORT1_IN);     // [RQ18]
    assign port2_rd = pgpio_read_mix(st_r.port2_dir, st_r.port2_latch, I_PORT2_IN); // [RQ18]

    assign setup_ph = I_APB.psel && !I_APB.penable;
    assign wr_acc   = I_APB.psel && I_APB.penable && I_APB.pwrite && I_CE;
    assign wdata16  = I_APB.pwdata[15:0];

    assign mapped = pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_LOW_DIRECTION)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_HIGH_DIRECTION)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DRIVER_TYPE)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DATA_LATCH)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DIRECTION)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_LOW_DATA)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_HIGH_DATA)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_IRQ_STATUS)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_IRQ_MASK)
                 || pgpio_hit(I_APB.paddr, PGPIO_IDX_EDGE_SELECT);

    // capture sees the pin itself, so address changes trigger it too
    pgpio_capture u_capture (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_ce      (I_CE),
        .i_lines   (I_PORT1_IN[PGPIO_CAP_LSB +: PGPIO_CAP_N]),      // [RQ3] [RQ5]
        .o_sampled (cap_sampled),
        .o_rise    (cap_rise),
        .o_fall    (cap_fall)
    );

    assign cap_events = (cap_rise & st_r.edge_sel[PGPIO_EDGE_RISE_LSB +: PGPIO_CAP_N])
                      | (cap_fall & st_r.edge_sel[PGPIO_EDGE_FALL_LSB +: PGPIO_CAP_N]);

    always_comb begin
        st_nxt = st_r;

        // read data captured in the setup cycle, presented in the access cycle
        if (setup_ph) begin
            st_nxt.rd_err = !mapped;
            st_nxt.prdata = 32'h0000_0000;
            if (!I_APB.pwrite) begin
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_LOW_DIRECTION)) begin
                    st_nxt.prdata[7:0] = st_r.port1_lo_dir;        // [RQ1]
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_HIGH_DIRECTION)) begin
                    st_nxt.prdata[7:0] = st_r.port1_hi_dir;        // [RQ1]
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_LOW_DATA)) begin
                    st_nxt.prdata[7:0] = port1_rd[7:0];            // [RQ18]
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_HIGH_DATA)) begin
                    st_nxt.prdata[7:0] = port1_rd[15:8];           // [RQ18]
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DATA_LATCH)) begin
                    st_nxt.prdata[15:0] = port2_rd;                // [RQ15] [RQ18]
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DIRECTION)) begin
                    st_nxt.prdata[15:0] = st_r.port2_dir;          // [RQ12]
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DRIVER_TYPE)) begin
                    st_nxt.prdata[15:0] = st_r.port2_drv;
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_IRQ_STATUS)) begin
                    st_nxt.prdata[3:0] = st_r.irq_status;
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_IRQ_MASK)) begin
                    st_nxt.prdata[3:0] = st_r.irq_mask;
                end
                if (pgpio_hit(I_APB.paddr, PGPIO_IDX_EDGE_SELECT)) begin
                    st_nxt.prdata[7:0] = st_r.edge_sel;
                end
            end
        end

        if (wr_acc) begin
            // reserved bits 15-8 are dropped
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_LOW_DIRECTION)) begin
                st_nxt.port1_lo_dir = wdata16[7:0];                // [RQ1] [RQ16]
            end
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_HIGH_DIRECTION)) begin
                st_nxt.port1_hi_dir = wdata16[7:0];                // [RQ1] [RQ16]
            end
            // bus owns the latch while it has the port; software writes are lost
            if (!takeover && pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_LOW_DATA)) begin
                st_nxt.port1_lo_latch = wdata16[7:0];              // [RQ16] [RQ10]
            end
            if (!takeover && pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT1_HIGH_DATA)) begin
                st_nxt.port1_hi_latch = wdata16[7:0];              // [RQ16] [RQ10]
            end
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DATA_LATCH)) begin
                st_nxt.port2_latch = wdata16;                      // [RQ15]
            end
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DIRECTION)) begin
                st_nxt.port2_dir = wdata16;                        // [RQ12] [RQ13]
            end
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_PORT2_DRIVER_TYPE)) begin
                st_nxt.port2_drv = wdata16;                        // [RQ14]
            end
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_IRQ_MASK)) begin
                st_nxt.irq_mask = wdata16[3:0];
            end
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_EDGE_SELECT)) begin
                st_nxt.edge_sel = wdata16[7:0];
            end
            if (pgpio_hit(I_APB.paddr, PGPIO_IDX_IRQ_STATUS)) begin
                st_nxt.irq_status = st_r.irq_status & ~wdata16[3:0];
            end
        end

        // new events win over a same-cycle clear
        st_nxt.irq_status = st_nxt.irq_status | cap_events;

        // alternate address replaces internal bus at the latch input
        if (takeover && I_BUS.addr_load) begin
            st_nxt.port1_lo_latch = I_BUS.addr[7:0];               // [RQ7] [RQ9]
            st_nxt.port1_hi_latch = I_BUS.addr[15:8];              // [RQ2] [RQ7]
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_r.port1_lo_dir   <= PGPIO_RST_HALF_DIR;
            st_r.port1_hi_dir   <= PGPIO_RST_HALF_DIR;
            st_r.port1_lo_latch <= PGPIO_RST_HALF_DATA;
            st_r.port1_hi_latch <= PGPIO_RST_HALF_DATA;
            st_r.port2_latch    <= PGPIO_RST_PORT2;
            st_r.port2_dir      <= PGPIO_RST_PORT2;
            st_r.port2_drv      <= PGPIO_RST_PORT2;
            st_r.irq_status     <= PGPIO_RST_IRQ;
            st_r.irq_mask       <= PGPIO_RST_IRQ;
            st_r.edge_sel       <= PGPIO_RST_EDGE;
            st_r.prdata         <= 32'h0000_0000;
            st_r.rd_err         <= 1'b0;
        end else if (I_CE) begin
            st_r <= st_nxt;
        end
    end

    // first port has no open-drain option
    pgpio_pad u_pad_port1 (
        .i_latch (port1_latch),
        .i_dir   (port1_dir_eff),
        .i_od    (16'h0000),
        .o_out   (O_PORT1_OUT),
        .o_oe    (O_PORT1_OE)
    );

    pgpio_pad u_pad_port2 (
        .i_latch (st_r.port2_latch),
        .i_dir   (st_r.port2_dir),
        .i_od    (st_r.port2_drv),
        .o_out   (O_PORT2_OUT),
        .o_oe    (O_PORT2_OE)
    );

    // a frozen clock enable also holds off bus transfers
    assign O_APB.pready  = I_CE;
    assign O_APB.prdata  = st_r.prdata;
    assign O_APB.pslverr = I_APB.psel && I_APB.penable && st_r.rd_err;

    assign O_CAPTURE     = cap_sampled;                            // [RQ3]
    assign O_CAPTURE_EVT = cap_events;
    assign O_IRQ         = |(st_r.irq_status & st_r.irq_mask);

endmodule

// ===== verif/pgpio_top_assertions.sv
/*
 * Port-level checker for pgpio_top: takeover, capture timing, interrupt cause.
 * Assumes it is bound into pgpio_top and sees that module's ports only.
 */
`timescale 1ns/1ns
module pgpio_checker
    import pgpio_pkg::*;
(
    input wire logic                    I_CLK,
    input wire logic                    I_RESET_N,
    input wire logic                    I_CE,
    input wire pgpio_apb_req_type       I_APB,
    input wire pgpio_bus_type           I_BUS,
    input wire logic [PGPIO_PORT_W-1:0] I_PORT1_IN,
    input wire logic [PGPIO_PORT_W-1:0] O_PORT1_OUT,
    input wire logic [PGPIO_PORT_W-1:0] O_PORT1_OE,
    input wire logic [PGPIO_PORT_W-1:0] O_PORT2_OE,
    input wire logic [PGPIO_CAP_N-1:0]  O_CAPTURE,
    input wire logic [PGPIO_CAP_N-1:0]  O_CAPTURE_EVT,
    input wire logic                    O_IRQ
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    logic       take;
    logic       wr_acc;
    logic       evt_any;
    logic [3:0] cap_pins;
    assign take     = I_BUS.ext_en & I_BUS.demux_sel;
    assign wr_acc   = I_APB.psel & I_APB.penable & I_APB.pwrite & I_CE;
    assign evt_any  = |O_CAPTURE_EVT;
    assign cap_pins = I_PORT1_IN[15:12];

    sequence s_load;
        take && I_BUS.addr_load && I_CE;
    endsequence
    sequence s_shown;
        !take || O_PORT1_OUT == ($past(I_BUS.addr) & O_PORT1_OE);
    endsequence

    a_addr_shown: assert property (s_load |=> s_shown)
        else $error("address not shown on port one");
    a_takeover_dir: assert property (take |-> O_PORT1_OE == {16{I_BUS.addr_oe}})
        else $error("port one direction not from bus controller");
    a_gpio_dir_held: assert property (!take && !$past(take) && $changed(O_PORT1_OE)
        |-> $past(wr_acc))
        else $error("port one enable changed without a write");
    a_port2_dir_held: assert property ($changed(O_PORT2_OE) |-> $past(wr_acc))
        else $error("port two enable changed without a write");
    a_cap_spacing: assert property ($changed(O_CAPTURE) |=> $stable(O_CAPTURE)[*7])
        else $error("capture sampled closer than eight cycles");
    a_cap_value: assert property ($changed(O_CAPTURE) |->
        O_CAPTURE == $past(cap_pins))
        else $error("capture value differs from line levels");
    a_evt_on_sample: assert property (evt_any |-> $changed(O_CAPTURE))
        else $error("capture event outside a sample update");
    a_irq_cause: assert property ($rose(O_IRQ) |-> $past(evt_any) || $past(wr_acc))
        else $error("interrupt rose without cause");
endmodule

bind pgpio_top pgpio_checker pgpio_checker_inst (.I_CLK, .I_RESET_N, .I_CE, .I_APB, .I_BUS,
    .I_PORT1_IN, .O_PORT1_OUT, .O_PORT1_OE, .O_PORT2_OE, .O_CAPTURE, .O_CAPTURE_EVT, .O_IRQ);

// ===== verif/pgpio_pin_model.sv
/*
 * Outside devices on both ports: each pin is the block's drive, else an
 * outside driver, else a weak pull-up.
 * Assumes the bench sets the outside drive values and enables.
 */
`timescale 1ns/1ns
module pgpio_pin_model
    import pgpio_pkg::*;
(
    input  wire logic [PGPIO_PORT_W-1:0] i_out1,
    input  wire logic [PGPIO_PORT_W-1:0] i_oe1,
    input  wire logic [PGPIO_PORT_W-1:0] i_ext1,
    input  wire logic [PGPIO_PORT_W-1:0] i_ext1_en,
    input  wire logic [PGPIO_PORT_W-1:0] i_out2,
    input  wire logic [PGPIO_PORT_W-1:0] i_oe2,
    input  wire logic [PGPIO_PORT_W-1:0] i_ext2,
    input  wire logic [PGPIO_PORT_W-1:0] i_ext2_en,
    output logic      [PGPIO_PORT_W-1:0] o_pin1,
    output logic      [PGPIO_PORT_W-1:0] o_pin2
);
    // outside drivers back off wherever the port drives, address output included
    assign o_pin1 = (i_oe1 & i_out1) | (~i_oe1 & (~i_ext1_en | i_ext1));
    // released open-drain lines float up unless someone pulls them
    assign o_pin2 = (i_oe2 & i_out2) | (~i_oe2 & (~i_ext2_en | i_ext2));
endmodule

// ===== verif/port1_port2_gpio_control_bench.sv
/*
 * Self-checking bench for pgpio_top: registers over APB, both ports,
 * bus takeover, capture events and the interrupt.
 * Assumes pgpio_pin_model resolves the pins; clock enable held high.
 */
`timescale 1ns/1ns
module port1_port2_gpio_control_bench
    import pgpio_pkg::*;
;
    localparam logic [15:0] L_DIR = PGPIO_IDX_PORT1_LOW_DIRECTION;
    localparam logic [15:0] H_DIR = PGPIO_IDX_PORT1_HIGH_DIRECTION;
    localparam logic [15:0] L_DAT = PGPIO_IDX_PORT1_LOW_DATA;
    localparam logic [15:0] H_DAT = PGPIO_IDX_PORT1_HIGH_DATA;
    localparam logic [15:0] DRV2 = PGPIO_IDX_PORT2_DRIVER_TYPE;
    localparam logic [15:0] DAT2 = PGPIO_IDX_PORT2_DATA_LATCH;
    localparam logic [15:0] DIR2 = PGPIO_IDX_PORT2_DIRECTION;
    localparam logic [15:0] STS = PGPIO_IDX_IRQ_STATUS;
    localparam logic [15:0] MSK = PGPIO_IDX_IRQ_MASK;
    localparam logic [15:0] EDG = PGPIO_IDX_EDGE_SELECT;

    logic              clk, reset_n, ce, irq;
    pgpio_apb_req_type apb_q;
    pgpio_apb_rsp_type apb_s;
    pgpio_bus_type     bus_q;
    logic [15:0]       pin1, pin2, out1, oe1, out2, oe2, ext1, ext1_en, ext2, ext2_en;
    logic [3:0]        cap, evt;
    int                mismatches, compares;

    pgpio_top pgpio_top_inst (.I_CLK(clk), .I_RESET_N(reset_n), .I_CE(ce), .I_APB(apb_q),
        .O_APB(apb_s), .I_BUS(bus_q), .I_PORT1_IN(pin1), .O_PORT1_OUT(out1), .O_PORT1_OE(oe1),
        .I_PORT2_IN(pin2), .O_PORT2_OUT(out2), .O_PORT2_OE(oe2), .O_CAPTURE(cap),
        .O_CAPTURE_EVT(evt), .O_IRQ(irq));
    pgpio_pin_model pgpio_pin_model_inst (.i_out1(out1), .i_oe1(oe1), .i_ext1(ext1),
        .i_ext1_en(ext1_en), .i_out2(out2), .i_oe2(oe2), .i_ext2(ext2), .i_ext2_en(ext2_en),
        .o_pin1(pin1), .o_pin2(pin2));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t lines got %h expected %h", $time, got, exp);
        end
    endtask

    // outputs are sampled at the edge itself, i.e. the cycle just ended
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        apb_q <= '{1'b1, 1'b0, wr, {idx, 2'b00}, d};
        @(posedge clk);
        apb_q.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (apb_s.pready !== 1'b1);
        q = apb_s.prdata;
        e = apb_s.pslverr;
        apb_q <= '0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, idx, d, q, e);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, idx, 32'h0, q, e);
        chk_reg(q, exp);
    endtask

    task automatic t_reset;
        logic [15:0] regs [10] = '{L_DIR, H_DIR, L_DAT, H_DAT, DRV2, DAT2, DIR2, STS, MSK, EDG};
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 10; i++)
            rd(regs[i], 32'h0);
        apb(1'b0, 16'h0001, 32'h0, q, e);
        chk_reg({q[30:0], e}, 32'h1);
        chk_pin(oe1 | oe2, 16'h0);
    endtask

    task automatic t_port1;
        wr(L_DIR, 32'hFFFF_FF0F);
        wr(H_DIR, 32'h0000_00F0);
        wr(L_DAT, 32'h0000_00A5);
        wr(H_DAT, 32'h0000_003C);
        ext1 <= 16'h0A5A;
        rd(L_DIR, 32'h0000_000F);
        rd(L_DAT, 32'h0000_0055);
        wr(L_DAT, 32'h0000_0000);
        rd(H_DAT, 32'h0000_003A);
        chk_pin(oe1, 16'hF00F);
        chk_pin(out1 & oe1, 16'h3000);
    endtask

    task automatic t_port2;
        logic [15:0] dir, od, lat, oe, pin;
        od = 16'h0F0F;
        lat = 16'h3355;
        ext2 <= 16'hA0C0;
        ext2_en <= 16'hFF00;
        wr(DRV2, {16'h0, od});
        wr(DAT2, {16'h0, lat});
        for (int i = 0; i < 2; i++) begin
            dir = i ? 16'hFF00 : 16'h00FF;
            wr(DIR2, {16'h0, dir});
            oe = dir & (~od | ~lat);
            pin = (oe & lat & ~od) | (~oe & (16'h00FF | 16'hA0C0));
            chk_pin(oe2, oe);
            chk_pin(out2 & oe, lat & ~od & oe);
            rd(DAT2, {16'h0, (dir & lat) | (~dir & pin)});
        end
    endtask

    // no software write to the port one latch while the bus owns it
    task automatic t_takeover;
        bus_q <= '{1'b1, 1'b0, 1'b0, 1'b1, 16'h1234};
        repeat (2) @(posedge clk);
        chk_pin(oe1, 16'hF00F);
        bus_q.demux_sel <= 1'b1;
        bus_q.addr_load <= 1'b1;
        @(posedge clk);
        bus_q.addr_load <= 1'b0;
        @(posedge clk);
        chk_pin(oe1, 16'hFFFF);
        chk_pin(out1, 16'h1234);
        bus_q.addr <= 16'hA000;
        bus_q.addr_load <= 1'b1;
        repeat (20) @(posedge clk);
        chk_pin({12'h0, cap}, 16'h000A);
        bus_q <= '0;
        repeat (2) @(posedge clk);
        chk_pin(oe1, 16'hF00F);
    endtask

    task automatic t_capture;
        int n = 0;
        wr(H_DIR, 32'h0000_000F);
        repeat (20) @(posedge clk);
        wr(EDG, 32'h0000_00FF);
        wr(MSK, 32'h0000_000F);
        ext1 <= 16'h5A5A;
        do begin
            @(posedge clk);
            n++;
        end while (evt === 4'h0 && n < 40);
        chk_pin({cap, evt, 8'h0}, 16'h5500);
        @(posedge clk);
        chk_reg({31'h0, irq}, 32'h1);
        rd(STS, 32'h0000_0005);
        wr(STS, 32'h0000_0001);
        rd(STS, 32'h0000_0004);
        wr(MSK, 32'h0000_0001);
        chk_reg({31'h0, irq}, 32'h0);
        wr(STS, 32'h0000_000F);
        rd(STS, 32'h0000_0000);
        ext1 <= 16'h0A5A;
        repeat (17) @(posedge clk);
        rd(STS, 32'h0000_0005);
    endtask

    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        apb_q = '0;
        bus_q = '0;
        ext1 = 16'h0000;
        ext1_en = 16'hFFFF;
        ext2 = 16'h0000;
        ext2_en = 16'hFFFF;
        mismatches = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_port1;
        t_port2;
        t_takeover;
        t_capture;
        results;
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        results;
    end
endmodule
